// ==== clean_pkg.sv ====
package clean_pkg;
  // APB register byte offsets
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] duration_addr = 8'h04;
  localparam logic [7:0] interval_addr = 8'h08;
  localparam logic [7:0] recovery_addr = 8'h0c;
  localparam logic [7:0] status_addr = 8'h10;
  localparam logic [7:0] irq_status_addr = 8'h14;
  localparam logic [7:0] irq_mask_addr = 8'h18;
  localparam logic [7:0] remain_addr = 8'h1c;
  // Control fields
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_offline_bit = 1;
  localparam int ctrl_delay_bit = 2;
  // Interrupt event bits
  localparam int ev_clean_start = 0;
  localparam int ev_clean_end = 1;
  localparam int ev_online = 2;
  localparam int ev_delay = 3;
  localparam int ev_width = 4;
  // Times in seconds and the one-second tick at 250 MHz
  localparam int clk_mhz = 250;
  localparam int tick_cycles = clk_mhz * 1000000;
  localparam logic [31:0] duration_min_s = 32'h0000_0005;
  localparam logic [31:0] duration_max_s = 32'h0000_0258;
  localparam logic [31:0] interval_min_s = 32'h0000_012c;
  localparam logic [31:0] interval_max_s = 32'h0002_a300;
  localparam logic [31:0] recovery_min_s = 32'h0000_0005;
  localparam logic [31:0] recovery_max_s = 32'h0000_0258;
  // Reset values
  localparam logic [2:0] ctrl_reset = 3'h1;
  localparam logic [31:0] duration_reset = 32'h0000_001e;
  localparam logic [31:0] interval_reset = 32'h0000_0e10;
  localparam logic [31:0] recovery_reset = 32'h0000_003c;
  localparam logic [ev_width-1:0] mask_reset = 4'h0;

  typedef enum logic [3:0] {
    st_interval = 4'b0001,
    st_wait = 4'b0010,
    st_clean = 4'b0100,
    st_recover = 4'b1000
  } phase_e;
endpackage : clean_pkg

// ==== tick_if.sv ====
`timescale 1ns/100ps
// Seconds tick passing from the timebase to the sequencer
interface tick_if;
  logic tick;
  logic restart;
  modport src (output tick, input restart);
  modport dst (input tick, output restart);
endinterface : tick_if

// ==== sec_timebase.sv ====
`timescale 1ns/100ps
// Divides the core clock into a one-second tick
module sec_timebase #(
  parameter int period = clean_pkg::tick_cycles
) (
  input wire logic clk,
  input wire logic rst_b,
  tick_if.src tb
);
  logic [31:0] count;

  // Restart lets each phase start on a whole second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h0;
      tb.tick <= 1'b0;
    end else if (tb.restart) begin
      count <= 32'h0;
      tb.tick <= 1'b0;
    end else if (count == 32'(period - 1)) begin
      count <= 32'h0;
      tb.tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tb.tick <= 1'b0;
    end
  end
endmodule : sec_timebase

// ==== clean_sequencer.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - The clean relay stays on for a duration of 5 s to 10 min.
// - Cleans are spaced by an interval of 5 min to 48 h.
// - Off-line mode disables other relays and current output while cleaning.
// - Off-line mode holds off-line for a recovery of 5 s to 10 min after cleaning.
// - On-line mode with delay waits until every control relay is inactive.
// - While delayed the clean delay warning is raised.
// - Going off-line de-energises the set point relays and holds the current output.
// - Automatic off-line blocks output changes in both duration and recovery.
// - During the interval relays and current outputs run normally.
// - Asserting the digital input starts a clean cycle manually.
// - When enabled the cycle starts at power-up with the interval and repeats.
// - The cycle stops only when cleaning mode is deselected.
// - The cleaning device is powered through the dedicated clean relay output, not a set point relay.
// - Off-line de-energises the control relays, but not the clean relay, and freezes the current output.
module clean_sequencer #(
  parameter int tick_period = clean_pkg::tick_cycles,
  parameter int relay_count = 3,
  parameter int out_width = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic manual_clean,
  input wire logic [relay_count-1:0] control_relay_req,
  input wire logic [out_width-1:0] current_req,
  output logic clean_relay,
  output logic [relay_count-1:0] control_relay,
  output logic [out_width-1:0] current_out,
  output logic offline,
  output logic clean_delay_warning,
  output logic irq
);
  // Seconds timebase; a phase change restarts it so every phase
  // starts on a whole second
  tick_if tb ();
  sec_timebase #(.period(tick_period)) u_timebase (
    .clk(clk),
    .rst_b(rst_b),
    .tb(tb)
  );

  // Programmed set-up; times are whole seconds
  logic [2:0] ctrl;
  logic [31:0] duration;
  logic [31:0] interval;
  logic [31:0] recovery;
  logic [clean_pkg::ev_width-1:0] irq_status;
  logic [clean_pkg::ev_width-1:0] irq_mask;
  clean_pkg::phase_e phase;
  clean_pkg::phase_e next_phase;
  logic [31:0] remain;
  logic manual_q;
  logic enable;
  logic go_offline;
  logic delay_en;
  logic relays_idle;
  logic manual_edge;
  logic [clean_pkg::ev_width-1:0] events;
  // Derived controls shared by several registers
  logic freeze;
  logic clear_hit;
  logic [relay_count-1:0] next_relay;
  logic [clean_pkg::ev_width-1:0] next_status;

  // Clamp a programmed time into its legal range
  // Out-of-range writes snap to the nearest legal limit
  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  // Word access decode, used by the write paths only
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // Phases in which off-line mode holds the outputs
  function automatic logic offline_phase(input clean_pkg::phase_e p);
    offline_phase = (p == clean_pkg::st_clean) || (p == clean_pkg::st_recover);
  endfunction : offline_phase

  // Control fields, relay idle test and the manual edge
  assign enable = ctrl[clean_pkg::ctrl_enable_bit];
  assign go_offline = ctrl[clean_pkg::ctrl_offline_bit];
  assign delay_en = ctrl[clean_pkg::ctrl_delay_bit];
  assign relays_idle = (control_relay_req == '0);
  assign manual_edge = manual_clean && !manual_q;

  // Writes land at the access edge only
  logic wr_en;
  assign wr_en = psel && penable && pwrite;
  assign clear_hit = wr_en && hit(paddr, clean_pkg::irq_status_addr);

  // Manual input edge so a held switch starts one cycle only
  // Reset value matches the idle switch level, so no false start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      manual_q <= 1'b0;
    end else begin
      manual_q <= manual_clean;
    end
  end

  // Control word: enable, off-line mode and delay option
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= clean_pkg::ctrl_reset;
    end else if (wr_en && hit(paddr, clean_pkg::ctrl_addr)) begin
      ctrl <= pwdata[2:0];
    end
  end

  // Clean duration; clamped so the sequencer never sees an illegal span
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      duration <= clean_pkg::duration_reset;
    end else if (wr_en && hit(paddr, clean_pkg::duration_addr)) begin
      duration <= clamp(pwdata, clean_pkg::duration_min_s, clean_pkg::duration_max_s);
    end
  end

  // Interval between cleans, clamped on write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interval <= clean_pkg::interval_reset;
    end else if (wr_en && hit(paddr, clean_pkg::interval_addr)) begin
      interval <= clamp(pwdata, clean_pkg::interval_min_s, clean_pkg::interval_max_s);
    end
  end

  // Recovery time after an off-line clean, clamped on write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      recovery <= clean_pkg::recovery_reset;
    end else if (wr_en && hit(paddr, clean_pkg::recovery_addr)) begin
      recovery <= clamp(pwdata, clean_pkg::recovery_min_s, clean_pkg::recovery_max_s);
    end
  end

  // Interrupt mask, same layout as the status bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= clean_pkg::mask_reset;
    end else if (wr_en && hit(paddr, clean_pkg::irq_mask_addr)) begin
      irq_mask <= pwdata[clean_pkg::ev_width-1:0];
    end
  end

  // Phase transitions
  // Delay is judged on leaving the interval; the wait phase re-tests it
  always_comb begin
    next_phase = phase;
    case (phase)
      clean_pkg::st_interval: begin
        if ((remain <= 32'h1 && tb.tick) || manual_edge) begin
          if (!go_offline && delay_en && !relays_idle) begin
            next_phase = clean_pkg::st_wait;
          end else begin
            next_phase = clean_pkg::st_clean;
          end
        end
      end
      clean_pkg::st_wait: begin
        if (relays_idle || go_offline || !delay_en) begin
          next_phase = clean_pkg::st_clean;
        end
      end
      clean_pkg::st_clean: begin
        if (remain <= 32'h1 && tb.tick) begin
          next_phase = go_offline ? clean_pkg::st_recover : clean_pkg::st_interval;
        end
      end
      clean_pkg::st_recover: begin
        if (remain <= 32'h1 && tb.tick) begin
          next_phase = clean_pkg::st_interval;
        end
      end
      default: next_phase = clean_pkg::st_interval;
    endcase
  end

  // Any phase change restarts the seconds count
  assign tb.restart = (next_phase != phase);

  // Sequencer and seconds countdown; disable parks in interval
  // Remain reloads on every phase entry and counts whole seconds
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= clean_pkg::st_interval;
      remain <= clean_pkg::interval_reset;
    end else if (!enable) begin
      phase <= clean_pkg::st_interval;
      remain <= interval;
    end else if (next_phase != phase) begin
      phase <= next_phase;
      case (next_phase)
        clean_pkg::st_clean: remain <= duration;
        clean_pkg::st_recover: remain <= recovery;
        default: remain <= interval;
      endcase
    end else if (tb.tick && remain != 32'h0) begin
      remain <= remain - 32'h1;
    end
  end

  // One off-line term feeds the flag, the relay gates and the current hold
  assign freeze = enable && go_offline && offline_phase(next_phase);

  // Cleaner power follows the clean phase, one edge after the decision
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clean_relay <= 1'b0;
    end else begin
      clean_relay <= enable && (next_phase == clean_pkg::st_clean);
    end
  end

  // Off-line flag spans clean and recovery in off-line mode;
  // software reads it back in the status word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      offline <= 1'b0;
    end else begin
      offline <= freeze;
    end
  end

  // Warning only while a clean waits for the control relays
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clean_delay_warning <= 1'b0;
    end else begin
      clean_delay_warning <= enable && (next_phase == clean_pkg::st_wait);
    end
  end

  // One gate per control relay; off-line drops each to its off state.
  // A bit per relay keeps the relay count a free parameter
  for (genvar i = 0; i < relay_count; i = i + 1) begin : g_relay
    assign next_relay[i] = control_relay_req[i] && !freeze;
  end

  // Relays follow their commands one edge late
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control_relay <= '0;
    end else begin
      control_relay <= next_relay;
    end
  end

  // Current holds its last value rather than dropping to zero, so the
  // control loop sees no step while the sensor is rinsed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      current_out <= '0;
    end else if (!freeze) begin
      current_out <= current_req;
    end
  end

  // Event sources for the sticky status bits
  // Only a real phase change with the sequencer enabled raises one
  assign events[clean_pkg::ev_clean_start] = enable && tb.restart &&
                                             next_phase == clean_pkg::st_clean;
  assign events[clean_pkg::ev_clean_end] = enable && tb.restart &&
                                           phase == clean_pkg::st_clean;
  assign events[clean_pkg::ev_online] = enable && tb.restart &&
                                        phase == clean_pkg::st_recover;
  assign events[clean_pkg::ev_delay] = enable && tb.restart &&
                                       next_phase == clean_pkg::st_wait;

  // Per-bit next status; a new event wins over a clear in the same cycle
  for (genvar e = 0; e < clean_pkg::ev_width; e = e + 1) begin : g_sticky
    assign next_status[e] = events[e] || (irq_status[e] && !(clear_hit && pwdata[e]));
  end

  // Write one to clear the sticky event bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_status;
    end
  end

  // Registered so the pin stays clean while status and mask change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // APB ready in the access cycle, zero wait states
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Read data latched at setup so it stands through the access cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          clean_pkg::ctrl_addr: prdata <= {29'h0, ctrl};
          clean_pkg::duration_addr: prdata <= duration;
          clean_pkg::interval_addr: prdata <= interval;
          clean_pkg::recovery_addr: prdata <= recovery;
          clean_pkg::status_addr: prdata <= {26'h0, clean_delay_warning, offline,
                                             phase};
          clean_pkg::irq_status_addr: prdata <= {28'h0, irq_status};
          clean_pkg::irq_mask_addr: prdata <= {28'h0, irq_mask};
          clean_pkg::remain_addr: prdata <= remain;
          default: pslverr <= 1'b1; // Unmapped address
        endcase
      end
    end
  end
endmodule : clean_sequencer

// ==== clean_sequencer_monitor.sv ====
`timescale 1ns/100ps
module clean_sequencer_monitor #(
  parameter int tick_period = 10,
  parameter int relay_count = 3,
  parameter int out_width = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic manual_clean,
  input wire logic [relay_count-1:0] control_relay_req,
  input wire logic [out_width-1:0] current_req,
  input wire logic clean_relay,
  input wire logic [relay_count-1:0] control_relay,
  input wire logic [out_width-1:0] current_out,
  input wire logic offline,
  input wire logic clean_delay_warning
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  int on_cnt;
  // Relay on-time, restarted each time the cleaner loses power
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) on_cnt <= 0;
    else on_cnt <= clean_relay ? on_cnt + 1 : 0;
  end
  // Three cycles allow for the one-cycle lag of the registered outputs
  sequence held_off; offline [*3]; endsequence
  sequence online_run; !offline [*2]; endsequence
  apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  relays_dropped_a: assert property (held_off |-> control_relay == '0)
    else $error("relay on off-line");
  current_frozen_a: assert property (held_off |-> $stable(current_out))
    else $error("current moved");
  relays_follow_a: assert property (online_run |-> control_relay == $past(control_relay_req))
    else $error("relay lag");
  current_follow_a: assert property (online_run |-> current_out == $past(current_req))
    else $error("current lag");
  delay_quiet_a: assert property (clean_delay_warning |-> !clean_relay && !offline)
    else $error("clean while delayed");
  clean_span_a: assert property ($fell(clean_relay) |->
    on_cnt >= 5 * tick_period - 2 && on_cnt <= 600 * tick_period + 2)
    else $error("clean span");
  manual_start_a: assert property ($rose(manual_clean) && !clean_relay && !offline &&
    !clean_delay_warning |-> ##2 (clean_relay || clean_delay_warning)) else $error("no start");
endmodule : clean_sequencer_monitor

bind clean_sequencer clean_sequencer_monitor #(.tick_period(tick_period),
  .relay_count(relay_count), .out_width(out_width)) i_monitor (.clk, .rst_b, .psel,
  .penable, .pready, .pslverr, .manual_clean, .control_relay_req, .current_req,
  .clean_relay, .control_relay, .current_out, .offline, .clean_delay_warning);

// ==== clean_partner.sv ====
`timescale 1ns/100ps
// Remote clean switch and relay-powered cleaner
module clean_partner (
  input wire logic clk,
  input wire logic press,
  input wire logic clean_relay,
  output logic manual_clean,
  output int on_cycles
);
  logic was_on = 1'b0;
  // Contact closes one edge after the bench asks
  always_ff @(posedge clk) manual_clean <= press;
  // Cleaner run time; last run is kept for the bench
  always_ff @(posedge clk) begin
    was_on <= clean_relay;
    if (clean_relay) on_cycles <= was_on ? on_cycles + 1 : 1;
  end
endmodule : clean_partner

// ==== clean_sequencer_test.sv ====
`timescale 1ns/100ps
module clean_sequencer_test;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, press = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, err, manual_clean, clean_relay, offline, warn, irq;
  logic [2:0] req = 3'h0, control_relay;
  logic [15:0] cur = 16'h0000, current_out;
  int on_cycles, n, compares = 0, mismatches = 0;
  // 4 ns period
  always #2 clk = ~clk;
  clean_sequencer #(.tick_period(10)) i_clean_sequencer (.clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .manual_clean,
    .control_relay_req(req), .current_req(cur), .clean_relay, .control_relay,
    .current_out, .offline, .clean_delay_warning(warn), .irq);
  clean_partner i_clean_partner (.clk, .press, .clean_relay, .manual_clean, .on_cycles);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Idle edge first, so release and next setup never share a time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task pulse;
    press <= 1;
    repeat (6) @(posedge clk);
    press <= 0;
  endtask : pulse
  // Counts edges until the chosen output reaches the level
  task wt(input bit s, input logic v);
    n = 0;
    while ((s ? offline : clean_relay) !== v && n < 5000) begin
      n++;
      @(posedge clk);
    end
  endtask : wt
  task t_regs;
    rd(clean_pkg::ctrl_addr, 32'h1);
    rd(clean_pkg::duration_addr, 32'h1e);
    rd(clean_pkg::interval_addr, 32'he10);
    rd(clean_pkg::recovery_addr, 32'h3c);
    rd(clean_pkg::irq_mask_addr, 32'h0);
    rd(clean_pkg::status_addr, 32'h1);
    apb(1'b1, 8'h20, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, clean_pkg::duration_addr, 32'hffff_ffff);
    rd(clean_pkg::duration_addr, 32'h258);
    apb(1'b1, clean_pkg::duration_addr, 32'h0);
    apb(1'b1, clean_pkg::interval_addr, 32'h1);
    rd(clean_pkg::interval_addr, 32'h12c);
    apb(1'b1, clean_pkg::recovery_addr, 32'h0);
    rd(clean_pkg::recovery_addr, 32'h5);
  endtask : t_regs
  task t_offline;
    apb(1'b1, clean_pkg::irq_mask_addr, 32'hf);
    apb(1'b1, clean_pkg::ctrl_addr, 32'h3);
    req <= 3'h5;
    cur <= 16'h1234;
    pulse;
    chk(clean_relay, 1'b1);
    chk(control_relay, 3'h0);
    rd(clean_pkg::status_addr, 32'h14);
    cur <= 16'h4321;
    chk(irq, 1'b1);
    apb(1'b1, clean_pkg::irq_status_addr, 32'h1);
    wt(0, 1'b0);
    chk(on_cycles inside {[48:52]}, 1'b1);
    chk(current_out, 16'h1234);
    wt(1, 1'b0);
    chk(n inside {[47:53]}, 1'b1);
    rd(clean_pkg::status_addr, 32'h1);
    chk(current_out, 16'h4321);
    chk(control_relay, 3'h5);
    rd(clean_pkg::irq_status_addr, 32'h6);
    chk(irq, 1'b1);
    apb(1'b1, clean_pkg::irq_mask_addr, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, clean_pkg::irq_status_addr, 32'hf);
    apb(1'b1, clean_pkg::irq_mask_addr, 32'hf);
    @(posedge clk);
    chk(irq, 1'b0);
  endtask : t_offline
  task t_delay;
    apb(1'b1, clean_pkg::ctrl_addr, 32'h5);
    req <= 3'h1;
    pulse;
    chk(warn, 1'b1);
    rd(clean_pkg::status_addr, 32'h22);
    rd(clean_pkg::irq_status_addr, 32'h8);
    repeat (40) @(posedge clk);
    chk(clean_relay, 1'b0);
    req <= 3'h0;
    wt(0, 1'b1);
    chk(n < 6, 1'b1);
    chk(offline, 1'b0);
  endtask : t_delay
  // Automatic repeat after the interval, then stop by deselecting
  task t_repeat;
    wt(0, 1'b0);
    wt(0, 1'b1);
    chk(n inside {[2995:3005]}, 1'b1);
    wt(0, 1'b0);
    apb(1'b1, clean_pkg::ctrl_addr, 32'h0);
    repeat (3100) @(posedge clk);
    chk(clean_relay, 1'b0);
    rd(clean_pkg::status_addr, 32'h1);
    rd(clean_pkg::remain_addr, 32'h12c);
  endtask : t_repeat
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    t_regs;
    t_offline;
    t_delay;
    t_repeat;
    end_of_test;
  end
  // Run needs about 6500 cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule : clean_sequencer_test
